// ---- logic/ldm_pkg.sv ----
package ldm_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_US     = 1000;
  localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
  localparam int US_PER_MS     = 1000;
  localparam int ERR_PULSE_US  = 50;
  localparam int RETRY_MS      = 10;
  localparam int INIT_STEP_MS  = 10;
  localparam int NCH           = 24;
  localparam int CNT_W         = 16;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TIMER  = 8'h04;
  localparam logic [7:0] ADDR_GATE   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_CHEN   = 8'h10;

  localparam int CTRL_ALL_FAIL   = 0;
  localparam int CTRL_FORCE_ERR  = 1;
  localparam int CTRL_CLR_RESET  = 2;
  localparam int CTRL_CLR_FAULT  = 3;
  localparam int CTRL_FORCE_FS   = 4;
  localparam int CTRL_CLR_FS     = 5;
  localparam int CTRL_PROG_MODE  = 6;
  localparam int TIMER_INIT_LSB  = 0;
  localparam int TIMER_WDT_LSB   = 4;

  localparam logic [7:0]     GATE_KEY1   = 8'h5a;
  localparam logic [7:0]     GATE_KEY2   = 8'ha5;
  localparam logic [NCH-1:0] DEF_CHEN    = 24'hffffff;
  localparam logic           DEF_ALLFAIL = 1'b1;
  localparam logic [3:0]     DEF_SEL     = 4'h0;

  typedef enum logic [2:0] {
    ST_POR      = 3'b000,
    ST_INIT     = 3'b001,
    ST_NORMAL   = 3'b010,
    ST_FAILSAFE = 3'b011,
    ST_PROGRAM  = 3'b100
  } ldm_state_t;

  typedef struct packed {
    logic       all_fail_select;
    logic [3:0] init_delay_sel;
    logic [3:0] watchdog_period_sel;
  } ldm_cfg_t;

  typedef struct packed {
    logic crit;
    logic noncrit;
  } ldm_fault_t;

  function automatic logic [CNT_W-1:0] ldm_wdt_ms(input logic [3:0] sel);
    case (sel)
      4'h0:    ldm_wdt_ms = 16'h0001;
      4'h1:    ldm_wdt_ms = 16'h0002;
      4'h2:    ldm_wdt_ms = 16'h0005;
      4'h3:    ldm_wdt_ms = 16'h000a;
      4'h4:    ldm_wdt_ms = 16'h0014;
      4'h5:    ldm_wdt_ms = 16'h0032;
      4'h6:    ldm_wdt_ms = 16'h0064;
      4'h7:    ldm_wdt_ms = 16'h00c8;
      4'h8:    ldm_wdt_ms = 16'h01f4;
      4'h9:    ldm_wdt_ms = 16'h03e8;
      4'ha:    ldm_wdt_ms = 16'h07d0;
      4'hb:    ldm_wdt_ms = 16'h1388;
      default: ldm_wdt_ms = 16'h2710;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] ldm_init_ms(input logic [3:0] sel);
    ldm_init_ms = CNT_W'((int'(sel) + 1) * INIT_STEP_MS);
  endfunction

endpackage

// ---- logic/ldm_sync3.sv ----
`timescale 1ns/10ps
module ldm_sync3 #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A change is accepted once the second and third stages agree.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      dout <= RST_VAL;
    else if (s2_ff == s3_ff)
      dout <= s3_ff;
  end

endmodule

// ---- logic/ldm_timebase.sv ----
`timescale 1ns/10ps
module ldm_timebase #(
  parameter int US_PER_MS_P = ldm_pkg::US_PER_MS
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Ticks
  output logic      us_tick,
  output logic      ms_tick
);
  import ldm_pkg::*;

  logic [CNT_W-1:0] cyc_ff;
  logic [CNT_W-1:0] us_ff;

  // One counter chain provides every delay of the block.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cyc_ff  <= '0;
      us_ff   <= '0;
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
    end
    else
    begin
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
      if (cyc_ff == CNT_W'(CYC_PER_US - 1))
      begin
        cyc_ff  <= '0;
        us_tick <= 1'b1;
        if (us_ff == CNT_W'(US_PER_MS_P - 1))
        begin
          us_ff   <= '0;
          ms_tick <= 1'b1;
        end
        else
          us_ff <= us_ff + 1'b1;
      end
      else
        cyc_ff <= cyc_ff + 1'b1;
    end
  end

endmodule

// ---- logic/ldm_mode_ctrl.sv ----
`timescale 1ns/10ps
module ldm_mode_ctrl #(
  parameter int US_PER_MS_P = ldm_pkg::US_PER_MS
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // APB slave
  input  wire logic [7:0]               paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Supply monitors
  input  wire logic                     bat_ok_pin,
  input  wire logic                     reg_ok_pin,
  // Serial link and nonvolatile store
  input  wire logic                     frame_ok,
  input  wire ldm_pkg::ldm_cfg_t        nv_cfg,
  input  wire logic [7:0]               stored_config_checksum,
  input  wire logic [7:0]               computed_config_checksum,
  input  wire logic                     checksum_valid,
  // Fault sources
  input  wire ldm_pkg::ldm_fault_t      fault_in,
  input  wire logic [ldm_pkg::NCH-1:0]  chan_fail,
  // Shared fault line
  input  wire logic                     fault_line_i,
  output logic                          fault_line_o,
  output logic                          fault_line_oe,
  // Channel and mode outputs
  output logic      [ldm_pkg::NCH-1:0]  chan_on,
  output logic      [ldm_pkg::NCH-1:0]  chan_diag_en,
  output logic                          serial_enable,
  output logic                          load_defaults,
  output ldm_pkg::ldm_state_t           op_state
);
  import ldm_pkg::*;

  // ----------------------------------------------------------------
  // Synchronisers and time base
  // ----------------------------------------------------------------
  logic             bat_ok;
  logic             reg_ok;
  logic             line_high;
  logic             us_tick;
  logic             ms_tick;

  ldm_sync3 #(.W(3), .RST_VAL(3'b001)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({bat_ok_pin, reg_ok_pin, fault_line_i}),
    .dout ({bat_ok, reg_ok, line_high})
  );

  ldm_timebase #(.US_PER_MS_P(US_PER_MS_P)) u_tb (
    .mclk    (mclk),
    .rst     (rst),
    .us_tick (us_tick),
    .ms_tick (ms_tick)
  );

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  ldm_state_t       nxt_state;
  ldm_cfg_t         cfg_ff;
  logic [NCH-1:0]   chen_ff;
  logic [1:0]       gate_ff;
  logic             rst_flag_ff;
  logic             fs_flag_ff;
  logic             err_flag_ff;
  logic             crc_flag_ff;
  logic [31:0]      nxt_rdata;
  logic             mapped;
  logic             setup;
  logic             wr;
  logic             wr_ctrl;
  logic             wr_timer;
  logic             force_err_req;
  logic             clr_rst_req;
  logic             clr_fault_req;
  logic             force_fs_req;
  logic             clr_fs_req;
  logic             prog_req;
  logic             prog_exit_req;
  logic             supply_ok;
  logic             enter_init;
  logic             enter_fs;

  assign setup     = psel & ~penable;
  assign mapped    = (paddr == ADDR_CTRL) | (paddr == ADDR_TIMER) | (paddr == ADDR_GATE)
                   | (paddr == ADDR_STATUS) | (paddr == ADDR_CHEN);
  assign wr        = psel & penable & pready & pwrite & ~pslverr;
  assign wr_ctrl   = wr & (paddr == ADDR_CTRL);
  assign wr_timer  = wr & (paddr == ADDR_TIMER);
  assign supply_ok = bat_ok & reg_ok;

  // Command bits are strobes only; they are never stored, and all but the program-mode bit (which reads back ST_PROGRAM) read back as zero.
  assign force_err_req = wr_ctrl & pwdata[CTRL_FORCE_ERR] & (op_state == ST_NORMAL);
  assign clr_rst_req   = wr_ctrl & pwdata[CTRL_CLR_RESET] & (op_state == ST_INIT);
  assign clr_fault_req = wr_ctrl & pwdata[CTRL_CLR_FAULT];
  assign force_fs_req  = wr_ctrl & pwdata[CTRL_FORCE_FS] & (op_state == ST_NORMAL);
  assign clr_fs_req    = wr_ctrl & pwdata[CTRL_CLR_FS] & (op_state == ST_FAILSAFE);
  assign prog_req      = wr_ctrl & pwdata[CTRL_PROG_MODE] & (gate_ff == 2'b10);
  assign prog_exit_req = wr_ctrl & ~pwdata[CTRL_PROG_MODE] & (op_state == ST_PROGRAM);

  always_comb
  begin
    nxt_rdata = '0;
    unique case (paddr)
      ADDR_CTRL:
      begin
        nxt_rdata[CTRL_ALL_FAIL]  = cfg_ff.all_fail_select;
        nxt_rdata[CTRL_PROG_MODE] = (op_state == ST_PROGRAM);
      end
      ADDR_TIMER:
      begin
        nxt_rdata[TIMER_INIT_LSB +: 4] = cfg_ff.init_delay_sel;
        nxt_rdata[TIMER_WDT_LSB +: 4]  = cfg_ff.watchdog_period_sel;
      end
      ADDR_GATE:   nxt_rdata[1:0] = gate_ff;
      ADDR_STATUS: nxt_rdata[8:0] = {line_high, crc_flag_ff, err_flag_ff, fs_flag_ff,
                                     rst_flag_ff, serial_enable, op_state};
      ADDR_CHEN:   nxt_rdata[NCH-1:0] = chen_ff;
      default:     nxt_rdata = '0;
    endcase
  end

  // Zero-wait slave: pready rises in the access phase; reset state refuses access.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & (~mapped | (op_state == ST_POR));
      prdata  <= (setup & ~pwrite) ? nxt_rdata : '0;
    end
  end

  // ----------------------------------------------------------------
  // Operating state
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] init_cnt_ff;
  logic [CNT_W-1:0] wdt_cnt_ff;
  logic             init_done;
  logic             wdt_over;

  assign init_done = init_cnt_ff >= ldm_init_ms(cfg_ff.init_delay_sel);
  assign wdt_over  = wdt_cnt_ff >= ldm_wdt_ms(cfg_ff.watchdog_period_sel);

  always_comb
  begin
    nxt_state = op_state;
    if (!supply_ok)
      nxt_state = ST_POR;
    else
    begin
      unique case (op_state)
        ST_POR:      nxt_state = ST_INIT;
        ST_INIT:     if (clr_rst_req || init_done) nxt_state = ST_NORMAL;
        ST_NORMAL:
        begin
          if (wdt_over || force_fs_req)
            nxt_state = ST_FAILSAFE;
          else if (prog_req)
            nxt_state = ST_PROGRAM;
        end
        ST_FAILSAFE: if (clr_fs_req && !fs_flag_ff) nxt_state = ST_NORMAL;
        ST_PROGRAM:  if (prog_exit_req) nxt_state = ST_NORMAL;
        default:     nxt_state = ST_POR;
      endcase
    end
  end

  assign enter_init = (nxt_state == ST_INIT) & (op_state != ST_INIT);
  assign enter_fs   = (nxt_state == ST_FAILSAFE) & (op_state != ST_FAILSAFE);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      op_state      <= ST_POR;
      serial_enable <= 1'b0;
      load_defaults <= 1'b0;
    end
    else
    begin
      op_state      <= nxt_state;
      serial_enable <= (nxt_state != ST_POR);
      load_defaults <= enter_init | enter_fs;
    end
  end

  // Delay counters advance on the shared millisecond tick.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      init_cnt_ff <= '0;
      wdt_cnt_ff  <= '0;
    end
    else
    begin
      if (op_state != ST_INIT)
        init_cnt_ff <= '0;
      else if (ms_tick && !init_done)
        init_cnt_ff <= init_cnt_ff + 1'b1;
      if (op_state != ST_NORMAL || frame_ok)
        wdt_cnt_ff <= '0;
      else if (ms_tick && !wdt_over)
        wdt_cnt_ff <= wdt_cnt_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cfg_ff  <= '{DEF_ALLFAIL, DEF_SEL, DEF_SEL};
      chen_ff <= DEF_CHEN;
    end
    else if (op_state == ST_POR)
    begin
      cfg_ff  <= '{DEF_ALLFAIL, DEF_SEL, DEF_SEL};
      chen_ff <= DEF_CHEN;
    end
    else if (enter_init || enter_fs)
    begin
      cfg_ff  <= nv_cfg;
      chen_ff <= DEF_CHEN;
    end
    else
    begin
      if (wr_ctrl)
        cfg_ff.all_fail_select <= pwdata[CTRL_ALL_FAIL];
      if (wr_timer)
      begin
        cfg_ff.init_delay_sel      <= pwdata[TIMER_INIT_LSB +: 4];
        cfg_ff.watchdog_period_sel <= pwdata[TIMER_WDT_LSB +: 4];
      end
      if (wr && paddr == ADDR_CHEN)
        chen_ff <= pwdata[NCH-1:0];
    end
  end

  // Two-key gate; any other value or leaving normal operation relocks it.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      gate_ff <= 2'b00;
    else if (op_state != ST_NORMAL)
      gate_ff <= 2'b00;
    else if (wr && paddr == ADDR_GATE)
    begin
      if (pwdata[7:0] == GATE_KEY1)
        gate_ff <= 2'b01;
      else if (pwdata[7:0] == GATE_KEY2 && gate_ff == 2'b01)
        gate_ff <= 2'b10;
      else
        gate_ff <= 2'b00;
    end
  end

  // ----------------------------------------------------------------
  // Fault flags
  // ----------------------------------------------------------------
  logic             noncrit_q_ff;
  logic             crc_bad;

  assign crc_bad = checksum_valid & (stored_config_checksum != computed_config_checksum);

  // A set in the same cycle as a clear wins.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rst_flag_ff  <= 1'b1;
      fs_flag_ff   <= 1'b0;
      err_flag_ff  <= 1'b0;
      crc_flag_ff  <= 1'b0;
      noncrit_q_ff <= 1'b0;
    end
    else
    begin
      noncrit_q_ff <= fault_in.noncrit;
      if (op_state == ST_POR)
        rst_flag_ff <= 1'b1;
      else if (clr_rst_req)
        rst_flag_ff <= 1'b0;
      if (enter_fs)
        fs_flag_ff <= 1'b1;
      else if (clr_fault_req)
        fs_flag_ff <= 1'b0;
      if (crc_bad)
        crc_flag_ff <= 1'b1;
      else if (clr_fault_req)
        crc_flag_ff <= 1'b0;
      if (force_err_req || crc_bad || fault_in.crit || fault_in.noncrit)
        err_flag_ff <= 1'b1;
      else if (clr_fault_req)
        err_flag_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Error pulse and channel retry
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] pulse_cnt_ff;
  logic [CNT_W-1:0] retry_cnt_ff;
  logic             retry_ff;
  logic [NCH-1:0]   failed_ff;
  logic [NCH-1:0]   seen_ff;
  logic             in_fs;
  logic             own_fail;

  assign in_fs    = (op_state == ST_FAILSAFE);
  assign own_fail = |failed_ff;

  // One extra microsecond keeps the pulse at least its full width.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pulse_cnt_ff <= '0;
    else if (op_state != ST_NORMAL)
      pulse_cnt_ff <= '0;
    else if (force_err_req || (fault_in.noncrit && !noncrit_q_ff))
      pulse_cnt_ff <= CNT_W'(ERR_PULSE_US + 1);
    else if (us_tick && pulse_cnt_ff != '0)
      pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
  end

  // A failed channel is retried for one millisecond every ten.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      retry_cnt_ff <= '0;
      retry_ff     <= 1'b0;
      failed_ff    <= '0;
      seen_ff      <= '0;
    end
    else if (!in_fs)
    begin
      retry_cnt_ff <= '0;
      retry_ff     <= 1'b0;
      failed_ff    <= '0;
      seen_ff      <= '0;
    end
    else
    begin
      if (ms_tick)
        retry_cnt_ff <= (retry_cnt_ff == CNT_W'(RETRY_MS - 1)) ? '0 : retry_cnt_ff + 1'b1;
      if (ms_tick && retry_ff)
      begin
        retry_ff  <= 1'b0;
        failed_ff <= (seen_ff | chan_fail) & chen_ff;
        seen_ff   <= '0;
      end
      else if (retry_ff)
        seen_ff <= seen_ff | chan_fail;
      else
      begin
        retry_ff  <= ms_tick && own_fail && retry_cnt_ff == CNT_W'(RETRY_MS - 1);
        failed_ff <= failed_ff | (chan_fail & chen_ff);
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel drive and fault line
  // ----------------------------------------------------------------
  logic [NCH-1:0]   nxt_on;
  logic [NCH-1:0]   nxt_diag;
  logic             nxt_oe;
  logic             ext_low;
  logic             all_off;

  assign ext_low = ~line_high & ~fault_line_oe;
  assign all_off = crc_flag_ff | fault_in.crit;

  always_comb
  begin
    nxt_on   = '0;
    nxt_diag = '0;
    nxt_oe   = 1'b0;
    unique case (op_state)
      ST_NORMAL:
      begin
        nxt_oe = all_off | (pulse_cnt_ff != '0);
        if (!all_off)
        begin
          nxt_on   = chen_ff;
          nxt_diag = chen_ff;
        end
      end
      ST_FAILSAFE:
      begin
        nxt_oe = all_off | own_fail;
        if (all_off)
          nxt_on = '0;
        else if (cfg_ff.all_fail_select)
        begin
          if (own_fail)
          begin
            nxt_on   = retry_ff ? failed_ff : '0;
            nxt_diag = nxt_on;
          end
          else if (!ext_low)
          begin
            nxt_on   = chen_ff;
            nxt_diag = chen_ff;
          end
        end
        else
        begin
          nxt_on   = chen_ff & ~(failed_ff & ~{NCH{retry_ff}});
          nxt_diag = chen_ff;
        end
      end
      default:
      begin
        nxt_on   = '0;
        nxt_diag = '0;
        nxt_oe   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      chan_on       <= '0;
      chan_diag_en  <= '0;
      fault_line_oe <= 1'b0;
      fault_line_o  <= 1'b0;
    end
    else
    begin
      chan_on       <= nxt_on;
      chan_diag_en  <= nxt_diag;
      fault_line_oe <= nxt_oe;
      fault_line_o  <= 1'b0;
    end
  end

endmodule

// ---- verif/ldm_properties.sv ----
`timescale 1ns/10ps
module ldm_properties (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  rst,
  // Register bus
  input wire logic [7:0]            paddr,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Supplies and faults
  input wire logic                  bat_ok_pin,
  input wire logic                  reg_ok_pin,
  input wire ldm_pkg::ldm_fault_t   fault_in,
  // Outputs
  input wire logic                  fault_line_o,
  input wire logic                  fault_line_oe,
  input wire logic [ldm_pkg::NCH-1:0] chan_on,
  input wire logic                  serial_enable,
  input wire logic                  load_defaults,
  input wire ldm_pkg::ldm_state_t   op_state
);
  import ldm_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic wr_ctrl;
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == ADDR_CTRL && !pslverr;
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready missing after setup");
  property p_por_err; psel && !penable && op_state == ST_POR |=> pslverr; endproperty
  a_por_err: assert property (p_por_err) else $error("access in reset not refused");
  property p_por_off;
    op_state == ST_POR && $past(op_state) == ST_POR |-> chan_on == '0 && !serial_enable;
  endproperty
  a_por_off: assert property (p_por_off) else $error("outputs live in reset state");
  property p_uv; (!(bat_ok_pin && reg_ok_pin)) [*7] |-> op_state == ST_POR; endproperty
  a_uv: assert property (p_uv) else $error("supply loss did not reset");
  property p_init_se; op_state == ST_INIT |-> serial_enable; endproperty
  a_init_se: assert property (p_init_se) else $error("serial off in init");
  property p_load;
    op_state != $past(op_state) && op_state inside {ST_INIT, ST_FAILSAFE} |-> load_defaults;
  endproperty
  a_load: assert property (p_load) else $error("defaults not loaded");
  property p_crit; op_state == ST_NORMAL && fault_in.crit |=> chan_on == '0; endproperty
  a_crit: assert property (p_crit) else $error("critical fault left outputs on");
  property p_od; fault_line_oe |-> !fault_line_o; endproperty
  a_od: assert property (p_od) else $error("fault line driven high");
  property p_ferr;
    wr_ctrl && pwdata[CTRL_FORCE_ERR] && op_state == ST_NORMAL |=> ##1 fault_line_oe [*8];
  endproperty
  a_ferr: assert property (p_ferr) else $error("forced error gave no pulse");
  property p_ffs;
    wr_ctrl && pwdata[CTRL_FORCE_FS] && op_state == ST_NORMAL |=> op_state == ST_FAILSAFE;
  endproperty
  a_ffs: assert property (p_ffs) else $error("forced fail-safe not entered");
  c_fs: cover property (op_state == ST_FAILSAFE);
  c_prog: cover property (op_state == ST_PROGRAM);
  c_pulse: cover property ($rose(fault_line_oe));
endmodule
bind ldm_mode_ctrl ldm_properties u_props (.*);

// ---- verif/ldm_host_model.sv ----
`timescale 1ns/10ps
module ldm_host_model #(
  parameter int GAP = 200
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Frame traffic
  input wire logic en,
  output logic     frame_ok
);
  // ----------------------------------------
  // Verified frames at a fixed spacing
  // ----------------------------------------
  int   cnt_ff;
  logic frame_ff;
  assign frame_ok = frame_ff;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff   <= 0;
      frame_ff <= 1'b0;
    end
    else
    begin
      cnt_ff   <= (cnt_ff == GAP - 1) ? 0 : cnt_ff + 1;
      frame_ff <= en && cnt_ff == GAP - 1;
    end
  end
endmodule

// ---- verif/test_ldm_mode_ctrl.sv ----
`timescale 1ns/10ps
module test_ldm_mode_ctrl;
  import ldm_pkg::*;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  logic           mclk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic           bat_ok_pin, reg_ok_pin, frame_ok, checksum_valid, host_en, ext_low;
  logic           fault_line_o, fault_line_oe, serial_enable, load_defaults;
  wire logic      fault_line_i;
  logic [7:0]     paddr, stored_config_checksum, computed_config_checksum;
  logic [31:0]    pwdata, prdata, rd;
  logic [NCH-1:0] chan_fail, chan_on, chan_diag_en;
  ldm_cfg_t       nv_cfg;
  ldm_fault_t     fault_in;
  ldm_state_t     op_state;
  int             fails, comparisons, n;
  assign fault_line_i = !(fault_line_oe || ext_low);
  ldm_mode_ctrl #(.US_PER_MS_P(4)) dut (.*);
  ldm_host_model host (.mclk(mclk), .rst(rst), .en(host_en), .frame_ok(frame_ok));
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n == 0 || pready !== 1'b1; n++)
    begin
      if (n > 16)
      begin
        fails++;
        give_verdict();
      end
      @(posedge mclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wst(input ldm_state_t s, input int lim);
    for (n = 0; op_state !== s; n++)
    begin
      if (n > lim)
      begin
        fails++;
        give_verdict();
      end
      @(posedge mclk);
    end
  endtask
  task automatic wlow();
    for (n = 0; fault_line_oe !== 1'b1 && n < 4; n++)
      @(posedge mclk);
    for (n = 0; fault_line_oe === 1'b1 && n < 14000; n++)
      @(posedge mclk);
    if (n >= 14000)
    begin
      fails++;
      give_verdict();
    end
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {bat_ok_pin, reg_ok_pin, checksum_valid, host_en, ext_low} = '0;
    {stored_config_checksum, computed_config_checksum} = '0;
    nv_cfg = '{1'b1, 4'h0, 4'h0};
    fault_in = '0;
    chan_fail = '0;
    tick(8);
    rst <= 1'b0;
    tick(2);
    apb(0, ADDR_STATUS, 0);
    chk("por_err", 1, er);
    chk("por_chan", 0, chan_on);
    bat_ok_pin <= 1'b1;
    reg_ok_pin <= 1'b1;
    wst(ST_INIT, 20);
    host_en <= 1'b1;
    apb(0, ADDR_STATUS, 0);
    chk("init_status", 32'h119, rd);
    apb(0, ADDR_CTRL, 0);
    chk("ctrl_default", 1, rd);
    wst(ST_NORMAL, 12000);
    chk("init_delay", 1, n > 8900);
    $display("TEST power_up end");
    apb(1, ADDR_CTRL, 32'h3);
    wlow();
    chk("err_pulse", 1, n > 12200 && n < 12800);
    apb(0, ADDR_STATUS, 0);
    chk("summary_err", 1, rd[6]);
    apb(0, ADDR_CTRL, 0);
    chk("err_selfclear", 1, rd);
    fault_in <= 2'b10;
    tick(3);
    chk("crit_off", 0, chan_on);
    chk("crit_line", 1, fault_line_oe);
    fault_in <= 2'b01;
    tick(3);
    chk("noncrit_on", 32'hffffff, chan_on);
    fault_in <= '0;
    stored_config_checksum   <= 8'h11;
    computed_config_checksum <= 8'h22;
    checksum_valid           <= 1'b1;
    tick(3);
    checksum_valid <= 1'b0;
    chk("crc_off", 0, chan_on);
    apb(0, ADDR_STATUS, 0);
    chk("crc_flag", 1, rd[7]);
    apb(1, ADDR_CTRL, 32'h9);
    tick(2);
    chk("crc_clear", 32'hffffff, chan_on);
    wlow();
    $display("TEST normal_faults end");
    apb(1, ADDR_TIMER, 32'h10);
    apb(0, ADDR_TIMER, 0);
    chk("timer_rd", 32'h10, rd);
    host_en <= 1'b0;
    wst(ST_FAILSAFE, 3000);
    chk("watchdog", 1, n > 700);
    host_en <= 1'b1;
    apb(0, ADDR_STATUS, 0);
    chk("fs_flag", 1, rd[5] && !er);
    ext_low <= 1'b1;
    tick(8);
    chk("ext_all_off", 0, chan_on);
    chk("ext_diag_off", 0, chan_diag_en);
    apb(1, ADDR_CTRL, 0);
    tick(2);
    chk("ext_sel0_on", 32'hffffff, chan_on);
    ext_low <= 1'b0;
    apb(1, ADDR_CTRL, 32'h20);
    chk("fs_stay", ST_FAILSAFE, op_state);
    apb(1, ADDR_CTRL, 32'h8);
    apb(1, ADDR_CTRL, 32'h20);
    chk("fs_exit", ST_NORMAL, op_state);
    apb(1, ADDR_CTRL, 32'h10);
    chk("force_fs", ST_FAILSAFE, op_state);
    chan_fail <= 24'h000001;
    tick(3);
    chk("own_off", 0, chan_on);
    chk("own_line", 1, fault_line_oe);
    apb(1, ADDR_CTRL, 0);
    tick(2);
    chk("own_sel0", 32'hfffffe, chan_on);
    chan_fail <= '0;
    apb(1, ADDR_CTRL, 32'h8);
    apb(1, ADDR_CTRL, 32'h20);
    $display("TEST fail_safe end");
    apb(1, ADDR_GATE, 32'h5a);
    apb(0, ADDR_GATE, 0);
    chk("gate_half", 1, rd);
    apb(1, ADDR_GATE, 32'ha5);
    apb(0, ADDR_GATE, 0);
    chk("gate_armed", 2, rd);
    apb(1, ADDR_CTRL, 32'h40);
    chk("program", ST_PROGRAM, op_state);
    reg_ok_pin <= 1'b0;
    tick(8);
    chk("supply_loss", ST_POR, op_state);
    reg_ok_pin <= 1'b1;
    wst(ST_INIT, 20);
    apb(1, ADDR_CTRL, 32'h4);
    chk("clear_reset", ST_NORMAL, op_state);
    apb(0, 8'h14, 0);
    chk("unmapped", 1, er);
    $display("TEST program_supply end");
    give_verdict();
  end
endmodule
